// ---- logic/can_err_status.sv ----
// error counters, error flags, options and timestamp register block
// Notes on behaviour
// - bit 15 enables the bus-off interrupt, bit 14 the error-summary interrupt
// - bit 12 loopback-silent; while set, self-rx-disable and delay-comp cannot be set
// - tx/rx warning interrupt enables writable only with warning feature on, else read zero
// - bit 7 chooses one or three samples per received bit
// - bit 6 set suppresses automatic bus-off recovery
// - bit 4 chooses priority order or lowest-number order for transmission
// - state 00 active, 01 passive, 1x bus-off; monitor plus reset blanks one bit
// - timer word shows the 16-bit timestamp counter, upper bits zero, word access only
// - mask bit 31 for rtr, 30 for ide, 28..0 for identifier; one compares
// - mask reset content undefined; writable only while inactive
// - counter word holds fd rx, fd tx, rx, tx counts; read-only unless inactive
// - fd counters may be written only with zero, only while inactive
// - fd data phase error flags in bits 31..26 without 29, cleared on read
// - bit 20 is the or of the five fd error flags
// - bit 21 sets when a new error comes while any error flag is set
// - bit 19 sets when the bus-off recovery sequence is seen
// - bit 18 shows bus synchronisation
// - bit 17 sets on tx warning rising, not while bus-off
// - bit 16 sets on rx warning rising, updated on networking-mode exit
// - bits 15..10 flag all-format errors, cleared on read, updated on networking exit
// - warning levels set while the matching counter is 96 or more
// - bits 7, 6, 3 show bus idle, transmitting, receiving; read-only
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module can_err_status
  import can_err_pkg::*;
(
  // clock, enable, reset
  input wire logic clk,
  input wire logic ce,
  input wire logic srst,
  // avalon-mm register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // unit mode and control
  input wire logic inactive_mode,
  input wire logic soft_reset_req,
  input wire logic pn_active,
  input wire logic pn_exit,
  input wire logic bit_tick,
  input wire logic ts_tick,
  // protocol engine reports
  input wire err_evt_s err_evt,
  input wire logic busoff_recov_evt,
  input wire logic cnt_load,
  input wire err_cnt_s cnt_in,
  input wire bus_stat_s stat_in,
  // options and values to the protocol engine
  output opt_s opt,
  output logic [31:0] mailbox_mask_bits,
  output logic [15:0] timestamp_value,
  output err_cnt_s err_counts,
  output logic [1:0] fault_confinement_state,
  // interrupt requests
  output logic busoff_irq,
  output logic err_summary_irq,
  output logic tx_warn_irq,
  output logic rx_warn_irq
);

  // ************
  // bus handshake
  // ************
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic req, rd_take, wr_take, word_ok;
  logic [31:0] rmux;

  // one wait state on every access keeps the read mux off the bus path
  always_comb
  begin
    req = avs_read | avs_write;
    ack_d = req & ~ack_q;
    rd_take = avs_read & ack_q;
    wr_take = avs_write & ack_q;
    word_ok = (avs_byteenable == 4'hf);
    rdata_d = (ack_d & avs_read) ? rmux : rdata_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = req & ~(ack_q & ce);
  assign avs_readdata = rdata_q;

  // ************
  // option and auxiliary control registers
  // ************
  logic [15:0] ctl1_q, ctl1_d, ctl1_wm;
  logic [2:0] aux_q, aux_d;
  logic warn_en, loop_sil;

  assign warn_en = aux_q[B_WARN_EN];
  assign loop_sil = ctl1_q[B_LOOP_SILENT];

  // option bits are untouched by the soft reset request
  always_comb
  begin
    ctl1_wm = CTL1_WMASK;
    if (!inactive_mode)
      ctl1_wm = ctl1_wm & ~CTL1_INA_MASK;
    if (!warn_en)
    begin
      ctl1_wm[B_TXWARN_IE] = 1'b0;
      ctl1_wm[B_RXWARN_IE] = 1'b0;
    end
    ctl1_d = ctl1_q;
    if (wr_take && avs_address == OFF_CTL1)
      ctl1_d = (ctl1_q & ~ctl1_wm) | (avs_writedata[15:0] & ctl1_wm);
    aux_d = aux_q;
    if (wr_take && avs_address == OFF_AUX)
    begin
      aux_d[B_WARN_EN] = avs_writedata[B_WARN_EN];
      aux_d[B_SELF_RX_DIS] = avs_writedata[B_SELF_RX_DIS] & ~loop_sil;
      aux_d[B_TDC_EN] = avs_writedata[B_TDC_EN] & ~loop_sil;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctl1_q <= CTL1_RST;
      aux_q <= AUX_RST;
    end
    else if (ce)
    begin
      ctl1_q <= ctl1_d;
      aux_q <= aux_d;
    end
  end

  // options to the engine; loop-silent also masks bits set before it
  always_comb
  begin
    opt.triple_sample_sel = ctl1_q[B_TRIPLE];
    opt.auto_recovery_off = ctl1_q[B_NO_RECOV];
    opt.tx_order_sel = ctl1_q[B_TX_ORDER];
    opt.listen_only_mode = ctl1_q[B_LISTEN];
    opt.loop_silent_mode = loop_sil;
    opt.time_sync_en = ctl1_q[B_TSYNC];
    opt.self_rx_disable = aux_q[B_SELF_RX_DIS] & ~loop_sil;
    opt.tx_delay_comp_en = aux_q[B_TDC_EN] & ~loop_sil;
    opt.warn_feature_en = warn_en;
  end

  // ************
  // timestamp counter and public mailbox mask
  // ************
  logic [15:0] ts_q, ts_d;
  logic [31:0] mask_q, mask_d;

  always_comb
  begin
    ts_d = ts_q;
    if (soft_reset_req)
      ts_d = TIMER_RST;
    else if (wr_take && avs_address == OFF_TIMER && word_ok)
      ts_d = avs_writedata[15:0];
    else if (ts_tick)
      ts_d = ts_q + 16'h0001;
    mask_d = mask_q;
    if (wr_take && avs_address == OFF_MASK && inactive_mode)
      mask_d = avs_writedata;
  end

  // mask has no meaningful reset content; zero is chosen for determinism
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ts_q <= TIMER_RST;
      mask_q <= MASK_RST;
    end
    else if (ce)
    begin
      ts_q <= ts_d;
      mask_q <= mask_d;
    end
  end

  assign timestamp_value = ts_q;
  assign mailbox_mask_bits = mask_q;

  // ************
  // error counters
  // ************
  err_cnt_s cnt_q, cnt_d;
  logic tx_lvl, rx_lvl;

  // engine updates win over a software write in the same cycle
  always_comb
  begin
    cnt_d = cnt_q;
    if (soft_reset_req)
      cnt_d = '0;
    else if (cnt_load)
      cnt_d = cnt_in;
    else if (wr_take && avs_address == OFF_ERR0 && word_ok && inactive_mode)
    begin
      cnt_d.rx_err_count = avs_writedata[15:8];
      cnt_d.tx_err_count = avs_writedata[7:0];
      if (avs_writedata[31:24] == 8'h00)
        cnt_d.fd_rx_err_count = 8'h00;
      if (avs_writedata[23:16] == 8'h00)
        cnt_d.fd_tx_err_count = 8'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cnt_q <= '0;
    else if (ce)
      cnt_q <= cnt_d;
  end

  assign err_counts = cnt_q;
  assign tx_lvl = (cnt_q.tx_err_count >= WARN_LIMIT);
  assign rx_lvl = (cnt_q.rx_err_count >= WARN_LIMIT);

  // ************
  // error and event flags
  // ************
  logic [4:0] fd_q, fd_d;
  logic [5:0] std_q, std_d, pend_q, pend_d, std_set;
  logic ovr_q, ovr_d, bor_q, bor_d, txw_q, txw_d, rxw_q, rxw_d;
  logic txl_q, rxl_q, prxw_q, prxw_d, rxw_set;
  logic rise_tx, rise_rx, any_flag, new_err, e1_rd, e1_wr;
  logic [31:0] rclr, wclr;

  // only bits that were actually returned are cleared, so an event
  // landing during the wait state survives the read
  always_comb
  begin
    e1_rd = rd_take && avs_address == OFF_ERR1;
    e1_wr = wr_take && avs_address == OFF_ERR1;
    rclr = e1_rd ? rdata_q : 32'h0000_0000;
    wclr = e1_wr ? avs_writedata : 32'h0000_0000;
    rise_tx = tx_lvl & ~txl_q & warn_en & ~stat_in.fault_state[1];
    rise_rx = rx_lvl & ~rxl_q & warn_en;
    any_flag = (|fd_q) | (|std_q);
    new_err = (|err_evt.fd) | (|err_evt.std);
    // while in pretended networking, hold all-format error events and rx warning rises back until the exit
    pend_d = pend_q;
    prxw_d = prxw_q;
    std_set = 6'h00;
    rxw_set = 1'b0;
    if (pn_active)
    begin
      pend_d = pend_q | err_evt.std;
      prxw_d = prxw_q | rise_rx;
    end
    else
    begin
      std_set = err_evt.std;
      rxw_set = rise_rx;
    end
    if (pn_exit)
    begin
      std_set = std_set | pend_d;
      rxw_set = rxw_set | prxw_d;
      pend_d = 6'h00;
      prxw_d = 1'b0;
    end
    // set wins over clear for every flag
    fd_d = (fd_q & ~{rclr[31:30], rclr[28:26]}) | err_evt.fd;
    std_d = (std_q & ~rclr[15:10]) | std_set;
    ovr_d = (ovr_q & ~wclr[E1_OVR]) | (new_err & any_flag);
    bor_d = (bor_q & ~wclr[E1_BOR]) | busoff_recov_evt;
    txw_d = (txw_q & ~wclr[E1_TXW_EV]) | rise_tx;
    rxw_d = (rxw_q & ~wclr[E1_RXW_EV]) | rxw_set;
    if (soft_reset_req)
    begin
      fd_d = 5'h00;
      std_d = 6'h00;
      ovr_d = 1'b0;
      bor_d = 1'b0;
      txw_d = 1'b0;
      rxw_d = 1'b0;
      pend_d = 6'h00;
      prxw_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fd_q <= 5'h00;
      std_q <= 6'h00;
      pend_q <= 6'h00;
      ovr_q <= 1'b0;
      bor_q <= 1'b0;
      txw_q <= 1'b0;
      rxw_q <= 1'b0;
      prxw_q <= 1'b0;
      txl_q <= 1'b0;
      rxl_q <= 1'b0;
    end
    else if (ce)
    begin
      fd_q <= fd_d;
      std_q <= std_d;
      pend_q <= pend_d;
      ovr_q <= ovr_d;
      bor_q <= bor_d;
      txw_q <= txw_d;
      rxw_q <= rxw_d;
      prxw_q <= prxw_d;
      txl_q <= tx_lvl;
      rxl_q <= rx_lvl;
    end
  end

  // ************
  // fault confinement state display
  // ************
  fs_state_e fs_q, fs_d;
  logic [1:0] fsv_q, fsv_d;

  // monitor mode plus soft reset blanks the field for one bit time
  always_comb
  begin
    fs_d = fs_q;
    case (fs_q)
      ST_LIVE:
        if (ctl1_q[B_LISTEN] && soft_reset_req)
          fs_d = ST_BLANK;
      ST_BLANK:
        if (bit_tick)
          fs_d = ST_MON;
      ST_MON:
        if (!ctl1_q[B_LISTEN])
          fs_d = ST_LIVE;
      default:
        fs_d = ST_LIVE;
    endcase
    case (fs_d)
      ST_BLANK: fsv_d = FS_ACTIVE;
      ST_MON: fsv_d = FS_PASSIVE;
      default: fsv_d = stat_in.fault_state;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fs_q <= ST_LIVE;
      fsv_q <= FS_ACTIVE;
    end
    else if (ce)
    begin
      fs_q <= fs_d;
      fsv_q <= fsv_d;
    end
  end

  assign fault_confinement_state = fsv_q;

  // ************
  // read mux and interrupt lines
  // ************
  logic [15:0] ctl1_rd;

  always_comb
  begin
    ctl1_rd = ctl1_q;
    ctl1_rd[B_TXWARN_IE] = ctl1_q[B_TXWARN_IE] & warn_en;
    ctl1_rd[B_RXWARN_IE] = ctl1_q[B_RXWARN_IE] & warn_en;
    rmux = 32'h0000_0000;
    case (avs_address)
      OFF_CTL1: rmux = {16'h0000, ctl1_rd};
      OFF_TIMER: rmux = word_ok ? {16'h0000, ts_q} : 32'h0000_0000;
      OFF_MASK: rmux = mask_q;
      OFF_ERR0: rmux = word_ok ? cnt_q : 32'h0000_0000;
      OFF_AUX: rmux = {29'h0000_0000, aux_q};
      OFF_ERR1:
      begin
        rmux[31:30] = fd_q[4:3];
        rmux[28:26] = fd_q[2:0];
        rmux[E1_OVR] = ovr_q;
        rmux[E1_FDSUM] = |fd_q;
        rmux[E1_BOR] = bor_q;
        rmux[E1_SYNC] = stat_in.bus_synced;
        rmux[E1_TXW_EV] = txw_q;
        rmux[E1_RXW_EV] = rxw_q;
        rmux[15:10] = std_q;
        rmux[9] = tx_lvl;
        rmux[8] = rx_lvl;
        rmux[7] = stat_in.bus_idle;
        rmux[6] = stat_in.transmitting;
        rmux[5:4] = fsv_q;
        rmux[3] = stat_in.receiving;
        rmux[2] = fsv_q[1];
        rmux[1] = |std_q;
      end
      default: rmux = 32'h0000_0000;
    endcase
  end

  // requests drop as soon as the flag is cleared or the enable removed
  assign busoff_irq = ctl1_q[B_BUSOFF_IE] & fsv_q[1];
  assign err_summary_irq = ctl1_q[B_ERRSUM_IE] & (|std_q);
  assign tx_warn_irq = ctl1_rd[B_TXWARN_IE] & txw_q;
  assign rx_warn_irq = ctl1_rd[B_RXWARN_IE] & rxw_q;

endmodule

`default_nettype wire

// ---- shared/can_err_pkg.sv ----
// constants and carriers for the error, status and option register block
`default_nettype none
package can_err_pkg;

  // ************
  // register byte offsets
  // ************
  localparam logic [7:0] OFF_CTL1 = 8'h04;
  localparam logic [7:0] OFF_TIMER = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_ERR0 = 8'h1c;
  localparam logic [7:0] OFF_ERR1 = 8'h20;
  localparam logic [7:0] OFF_AUX = 8'h40;

  // ************
  // option register field positions and masks
  // ************
  localparam int unsigned B_BUSOFF_IE = 15;
  localparam int unsigned B_ERRSUM_IE = 14;
  localparam int unsigned B_LOOP_SILENT = 12;
  localparam int unsigned B_TXWARN_IE = 11;
  localparam int unsigned B_RXWARN_IE = 10;
  localparam int unsigned B_TRIPLE = 7;
  localparam int unsigned B_NO_RECOV = 6;
  localparam int unsigned B_TSYNC = 5;
  localparam int unsigned B_TX_ORDER = 4;
  localparam int unsigned B_LISTEN = 3;
  localparam logic [15:0] CTL1_WMASK = 16'hdcf8;
  localparam logic [15:0] CTL1_INA_MASK = 16'h10b8;
  localparam logic [15:0] CTL1_RST = 16'h0000;

  // auxiliary control register fields
  localparam int unsigned B_WARN_EN = 0;
  localparam int unsigned B_SELF_RX_DIS = 1;
  localparam int unsigned B_TDC_EN = 2;
  localparam logic [2:0] AUX_RST = 3'h0;

  // ************
  // error flag register layout
  // ************
  localparam int unsigned E1_OVR = 21;
  localparam int unsigned E1_FDSUM = 20;
  localparam int unsigned E1_BOR = 19;
  localparam int unsigned E1_SYNC = 18;
  localparam int unsigned E1_TXW_EV = 17;
  localparam int unsigned E1_RXW_EV = 16;
  localparam int unsigned E1_STD_LSB = 10;

  // ************
  // reset values, thresholds and encodings
  // ************
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [7:0] WARN_LIMIT = 8'h60;
  localparam logic [1:0] FS_ACTIVE = 2'h0;
  localparam logic [1:0] FS_PASSIVE = 2'h1;

  // fd data phase errors: [4] recessive [3] dominant [2] crc [1] form [0] stuff
  // all-format errors: [5] recessive [4] dominant [3] ack [2] crc [1] form [0] stuff
  typedef struct packed {
    logic [4:0] fd;
    logic [5:0] std;
  } err_evt_s;

  typedef struct packed {
    logic [7:0] fd_rx_err_count;
    logic [7:0] fd_tx_err_count;
    logic [7:0] rx_err_count;
    logic [7:0] tx_err_count;
  } err_cnt_s;

  typedef struct packed {
    logic bus_synced;
    logic bus_idle;
    logic transmitting;
    logic receiving;
    logic [1:0] fault_state;
  } bus_stat_s;

  typedef struct packed {
    logic triple_sample_sel;
    logic auto_recovery_off;
    logic tx_order_sel;
    logic listen_only_mode;
    logic loop_silent_mode;
    logic time_sync_en;
    logic self_rx_disable;
    logic tx_delay_comp_en;
    logic warn_feature_en;
  } opt_s;

  typedef enum logic [2:0] {
    ST_LIVE = 3'b001,
    ST_BLANK = 3'b010,
    ST_MON = 3'b100
  } fs_state_e;

endpackage
`default_nettype wire

// ---- verif/can_engine_model.sv ----
// protocol engine stand-in: error events, counter loads, bus status, ticks
`timescale 1ns/1ps
`default_nettype none

module can_engine_model
  import can_err_pkg::*;
(
  // clock
  input wire logic clk,
  // engine reports
  output var err_evt_s err_evt,
  output var logic busoff_recov_evt,
  output var logic cnt_load,
  output var err_cnt_s cnt_in,
  output var bus_stat_s stat_in,
  output var logic bit_tick,
  output var logic ts_tick
);
  // ************
  // engine behaviour
  // ************
  logic [2:0] div_q;
  logic ts_en;
  initial
  begin
    err_evt = '0;
    busoff_recov_evt = 1'b0;
    cnt_load = 1'b0;
    cnt_in = '0;
    stat_in = '0;
    bit_tick = 1'b0;
    ts_tick = 1'b0;
    div_q = 3'h0;
    ts_en = 1'b0;
  end
  // bit time every eight clocks; timestamp counts bit times
  always @(posedge clk)
  begin
    div_q <= div_q + 3'h1;
    bit_tick <= (div_q == 3'h7);
    ts_tick <= ts_en && (div_q == 3'h7);
  end
  // one-cycle error or recovery report
  task pulse(input err_evt_s e, input logic rec);
    @(posedge clk);
    err_evt <= e;
    busoff_recov_evt <= rec;
    @(posedge clk);
    err_evt <= '0;
    busoff_recov_evt <= 1'b0;
    @(negedge clk);
  endtask
  // counter load; stale value inverted so nothing relies on it
  task load(input err_cnt_s c);
    @(posedge clk);
    cnt_in <= c;
    cnt_load <= 1'b1;
    @(posedge clk);
    cnt_load <= 1'b0;
    cnt_in <= ~c;
    @(negedge clk);
  endtask
  // bus status levels
  task set_stat(input bus_stat_s s);
    @(posedge clk);
    stat_in <= s;
  endtask
endmodule
`default_nettype wire

// ---- verif/can_err_status_props.sv ----
// concurrent checks on the ports of the error and status register block
`timescale 1ns/1ps
`default_nettype none

module can_err_status_props
  import can_err_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bus, mode and engine inputs
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic inactive_mode,
  input wire logic soft_reset_req,
  input wire logic bit_tick,
  input wire logic ts_tick,
  input wire logic cnt_load,
  input wire err_cnt_s cnt_in,
  // outputs under watch
  input wire opt_s opt,
  input wire logic [31:0] mailbox_mask_bits,
  input wire logic [15:0] timestamp_value,
  input wire err_cnt_s err_counts,
  input wire logic [1:0] fault_confinement_state
);
  // ************
  // properties
  // ************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic wr_ok;
  // a write that lands at this edge
  assign wr_ok = avs_write && !avs_waitrequest;

  a_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
  a_mask_locked: assert property (wr_ok && avs_address == OFF_MASK && !inactive_mode |=>
    $stable(mailbox_mask_bits)) else $error("mask changed outside inactive mode");
  a_mask_write: assert property (wr_ok && avs_address == OFF_MASK && inactive_mode &&
    avs_byteenable == 4'hf |=> mailbox_mask_bits == $past(avs_writedata))
    else $error("mask write lost");
  a_opt_locked: assert property (wr_ok && avs_address == OFF_CTL1 && !inactive_mode |=>
    $stable({opt.triple_sample_sel, opt.tx_order_sel, opt.listen_only_mode, opt.loop_silent_mode}))
    else $error("locked option changed outside inactive mode");
  a_ls_guard: assert property (opt.loop_silent_mode |->
    !opt.self_rx_disable && !opt.tx_delay_comp_en)
    else $error("option set during loopback silent");
  a_cnt_load: assert property (cnt_load && !soft_reset_req |=> err_counts == $past(cnt_in))
    else $error("counter load lost");
  a_cnt_locked: assert property (wr_ok && avs_address == OFF_ERR0 && !inactive_mode &&
    !cnt_load && !soft_reset_req |=> $stable(err_counts))
    else $error("counters written outside inactive mode");
  a_fd_zero: assert property (wr_ok && avs_address == OFF_ERR0 && avs_writedata[31:24] != 8'h0 &&
    avs_writedata[23:16] != 8'h0 && !cnt_load && !soft_reset_req |=> $stable(err_counts[31:16]))
    else $error("fd counter took a nonzero write");
  a_blank_state: assert property (opt.listen_only_mode && soft_reset_req && !bit_tick |=>
    fault_confinement_state == FS_ACTIVE) else $error("state not blanked");
  a_timer_step: assert property (ts_tick && !soft_reset_req &&
    !(wr_ok && avs_address == OFF_TIMER) |=> timestamp_value == $past(timestamp_value) + 16'h1)
    else $error("timestamp did not step");

  c_mask_write: cover property (wr_ok && avs_address == OFF_MASK && inactive_mode);
  c_cnt_load: cover property (cnt_load);
  c_blank: cover property (soft_reset_req && opt.listen_only_mode);
endmodule

bind can_err_status can_err_status_props can_err_status_props_i (.clk(clk), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .inactive_mode(inactive_mode),
  .soft_reset_req(soft_reset_req), .bit_tick(bit_tick), .ts_tick(ts_tick), .cnt_load(cnt_load),
  .cnt_in(cnt_in), .opt(opt), .mailbox_mask_bits(mailbox_mask_bits),
  .timestamp_value(timestamp_value), .err_counts(err_counts),
  .fault_confinement_state(fault_confinement_state));
`default_nettype wire

// ---- verif/can_err_status_tb_top.sv ----
// self-checking bench for the error, status and option register block
`timescale 1ns/1ps
`default_nettype none

module can_err_status_tb_top;
  import can_err_pkg::*;
  // ************
  // signals and instances
  // ************
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic clk, srst, ce, avs_read, avs_write, inactive_mode, soft_reset_req, pn_active, pn_exit;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r, mailbox_mask_bits;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, busoff_irq, err_summary_irq, tx_warn_irq, rx_warn_irq;
  logic busoff_recov_evt, cnt_load, bit_tick, ts_tick;
  logic [15:0] timestamp_value;
  logic [1:0] fault_confinement_state;
  err_evt_s err_evt;
  err_cnt_s cnt_in, err_counts, c;
  bus_stat_s stat_in, s;
  opt_s opt;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] seed = 32'h0000_ebfb; // xorshift start value
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;

  can_err_status can_err_status_i (.clk(clk), .ce(ce), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .inactive_mode(inactive_mode),
    .soft_reset_req(soft_reset_req), .pn_active(pn_active), .pn_exit(pn_exit),
    .bit_tick(bit_tick), .ts_tick(ts_tick), .err_evt(err_evt), .busoff_recov_evt(busoff_recov_evt),
    .cnt_load(cnt_load), .cnt_in(cnt_in), .stat_in(stat_in), .opt(opt),
    .mailbox_mask_bits(mailbox_mask_bits), .timestamp_value(timestamp_value),
    .err_counts(err_counts), .fault_confinement_state(fault_confinement_state),
    .busoff_irq(busoff_irq), .err_summary_irq(err_summary_irq), .tx_warn_irq(tx_warn_irq),
    .rx_warn_irq(rx_warn_irq));
  can_engine_model can_engine_model_i (.clk(clk), .err_evt(err_evt),
    .busoff_recov_evt(busoff_recov_evt), .cnt_load(cnt_load), .cnt_in(cnt_in),
    .stat_in(stat_in), .bit_tick(bit_tick), .ts_tick(ts_tick));

  // ************
  // helpers
  // ************
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done();
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one avalon cycle; held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // clock at 40 MHz
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // read data judged at its take edge against the oldest note
  always @(posedge clk)
  begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  // ************
  // main sequence
  // ************
  initial
  begin
    {srst, ce, inactive_mode} = 3'h7;
    {avs_read, avs_write, soft_reset_req, pn_active, pn_exit} = 5'h0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(OFF_ERR0, 32'h0, ALL);
    rd(OFF_TIMER, 32'h0, ALL);
    rd(8'h2c, 32'h0, ALL);
    wr(OFF_CTL1, 32'h0000_ffff);
    rd(OFF_CTL1, 32'h0000_d0f8, ALL);
    check(opt.triple_sample_sel & opt.auto_recovery_off & opt.tx_order_sel, 32'h1);
    wr(OFF_AUX, 32'h7);
    rd(OFF_AUX, 32'h1, ALL);
    wr(OFF_CTL1, 32'h0000_0c00);
    rd(OFF_CTL1, 32'h0000_0c00, ALL);
    wr(OFF_AUX, 32'h7);
    rd(OFF_AUX, 32'h7, ALL);
    wr(OFF_AUX, 32'h0);
    rd(OFF_CTL1, 32'h0, ALL);
    // locked option bits stay while the unit runs
    @(posedge clk) inactive_mode <= 1'b0;
    wr(OFF_CTL1, 32'h0000_dcf8);
    rd(OFF_CTL1, 32'h0000_c040, ALL);
    r = xs();
    wr(OFF_MASK, r);
    rd(OFF_MASK, 32'h0, ALL);
    @(posedge clk) inactive_mode <= 1'b1;
    wr(OFF_MASK, r);
    rd(OFF_MASK, r, ALL);
    check(mailbox_mask_bits, r);
    wr(OFF_TIMER, 32'habcd_1234);
    rd(OFF_TIMER, 32'h0000_1234, ALL);
    @(posedge clk) avs_byteenable <= 4'h3;
    rd(OFF_TIMER, 32'h0, ALL);
    @(posedge clk) avs_byteenable <= 4'hf;
    c = xs();
    can_engine_model_i.load(c);
    rd(OFF_ERR0, c, ALL);
    check(err_counts, c);
    wr(OFF_ERR0, 32'h0000_5a3c);
    rd(OFF_ERR0, 32'h0000_5a3c, ALL);
    wr(OFF_ERR0, 32'h1111_2233);
    rd(OFF_ERR0, 32'h0000_2233, ALL);
    @(posedge clk) inactive_mode <= 1'b0;
    wr(OFF_ERR0, 32'h0);
    rd(OFF_ERR0, 32'h0000_2233, ALL);
    // warning levels and their events
    wr(OFF_ERR1, 32'h0003_0000);
    wr(OFF_AUX, 32'h1);
    wr(OFF_CTL1, 32'h0000_0c00);
    can_engine_model_i.load(32'h0000_5f60);
    rd(OFF_ERR1, 32'h0002_0200, 32'h0003_0300);
    check({tx_warn_irq, rx_warn_irq}, 32'h2);
    can_engine_model_i.load(32'h0000_6060);
    rd(OFF_ERR1, 32'h0003_0300, 32'h0003_0300);
    wr(OFF_ERR1, 32'h0003_0000);
    rd(OFF_ERR1, 32'h0000_0300, 32'h0003_0300);
    check({tx_warn_irq, rx_warn_irq}, 32'h0);
    // error flags, summary, overrun
    wr(OFF_CTL1, 32'h0000_4000);
    can_engine_model_i.pulse(11'h021, 1'b0);
    check(err_summary_irq, 32'h1);
    rd(OFF_ERR1, 32'h0000_8400, 32'hfc3f_fc00);
    rd(OFF_ERR1, 32'h0, 32'hfc3f_fc00);
    check(err_summary_irq, 32'h0);
    can_engine_model_i.pulse(11'h540, 1'b0);
    can_engine_model_i.pulse(11'h001, 1'b0);
    rd(OFF_ERR1, 32'h9430_0400, 32'hfc3f_fc00);
    rd(OFF_ERR1, 32'h0020_0000, 32'hfc3f_fc00);
    wr(OFF_ERR1, 32'h0020_0000);
    rd(OFF_ERR1, 32'h0, 32'h0020_0000);
    can_engine_model_i.pulse(11'h000, 1'b1);
    rd(OFF_ERR1, 32'h0008_0000, 32'h0008_0000);
    // errors held while pretending, merged on exit
    @(posedge clk) pn_active <= 1'b1;
    can_engine_model_i.pulse(11'h010, 1'b0);
    rd(OFF_ERR1, 32'h0, 32'h0000_fc00);
    @(posedge clk) pn_exit <= 1'b1;
    @(posedge clk)
    begin
      pn_exit <= 1'b0;
      pn_active <= 1'b0;
    end
    rd(OFF_ERR1, 32'h0000_4000, 32'h0000_fc00);
    repeat (3)
    begin
      r = xs();
      s = r[5:0];
      s.fault_state = 2'h0;
      can_engine_model_i.set_stat(s);
      rd(OFF_ERR1, {13'h0, s.bus_synced, 10'h0, s.bus_idle, s.transmitting, 2'h0, s.receiving,
        3'h0}, 32'h0004_00c8);
    end
    // bus-off request follows the state while its enable is set
    wr(OFF_CTL1, 32'h0000_8000);
    s = '0;
    s.fault_state = 2'h2;
    can_engine_model_i.set_stat(s);
    repeat (3) @(posedge clk);
    @(negedge clk) check(busoff_irq, 32'h1);
    can_engine_model_i.set_stat('0);
    repeat (3) @(posedge clk);
    @(negedge clk) check(busoff_irq, 32'h0);
    // listen-only with soft reset blanks the state, then passive
    @(posedge clk) inactive_mode <= 1'b1;
    wr(OFF_CTL1, 32'h0000_0008);
    @(posedge clk) soft_reset_req <= 1'b1;
    @(posedge clk) soft_reset_req <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk) check(fault_confinement_state, FS_PASSIVE);
    rd(OFF_ERR1, 32'h0000_0010, 32'h0000_0030);
    can_engine_model_i.ts_en = 1'b1;
    repeat (40) @(posedge clk);
    rd(OFF_TIMER, 32'h0, 32'hffff_0000);
    test_done();
  end
endmodule
`default_nettype wire
